// File: src/csfl_pkg.sv
// csfl_pkg: constants shared by the condition-status flag logic
package csfl_pkg;
	localparam int          ADDR_W          = 5;
	// register byte offsets
	localparam logic [4:0]  OFS_STATUS      = 5'h00;
	localparam logic [4:0]  OFS_OP_CTRL     = 5'h04;
	localparam logic [4:0]  OFS_OPERANDS    = 5'h08;
	localparam logic [4:0]  OFS_RESULT      = 5'h0C;
	// status bit positions
	localparam int          FLG_CARRY       = 7;
	localparam int          FLG_ZERO        = 6;
	localparam int          FLG_SIGN        = 5;
	localparam int          FLG_OVFL        = 4;
	localparam int          FLG_DEC         = 3;
	localparam int          FLG_HALF        = 2;
	localparam int          FLG_FAST_IRQ    = 1;
	localparam int          FLG_BANK        = 0;
	localparam int          FLG_COND_LO     = 4;
	// op_ctrl field positions
	localparam int          OPC_OP_LO       = 0;
	localparam int          OPC_MODE_LO     = 5;
	localparam int          OPC_DST_FLAGS   = 8;
	// operands / result field positions
	localparam int          OPR_A_LO        = 0;
	localparam int          OPR_B_LO        = 8;
	localparam int          RES_ERR         = 8;
	localparam int          RES_MODE_LO     = 9;
	// reset values
	localparam logic [7:0]  RST_FLAGS       = 8'h00;
	localparam logic [7:0]  RST_SHADOW      = 8'h00;
	// operation codes
	localparam logic [4:0]  OP_NOP          = 5'h00;
	localparam logic [4:0]  OP_ADD          = 5'h01;
	localparam logic [4:0]  OP_ADC          = 5'h02;
	localparam logic [4:0]  OP_SUB          = 5'h03;
	localparam logic [4:0]  OP_SBC          = 5'h04;
	localparam logic [4:0]  OP_AND          = 5'h05;
	localparam logic [4:0]  OP_OR           = 5'h06;
	localparam logic [4:0]  OP_XOR          = 5'h07;
	localparam logic [4:0]  OP_RL           = 5'h08;
	localparam logic [4:0]  OP_RLC          = 5'h09;
	localparam logic [4:0]  OP_RR           = 5'h0A;
	localparam logic [4:0]  OP_RRC          = 5'h0B;
	localparam logic [4:0]  OP_SRA          = 5'h0C;
	localparam logic [4:0]  OP_SCF          = 5'h0D;
	localparam logic [4:0]  OP_RCF          = 5'h0E;
	localparam logic [4:0]  OP_CCF          = 5'h0F;
	localparam logic [4:0]  OP_SEL_BANK0    = 5'h10;
	localparam logic [4:0]  OP_SEL_BANK1    = 5'h11;
	localparam logic [4:0]  OP_FAST_IRQ     = 5'h12;
	localparam logic [4:0]  OP_IRQ_RETURN   = 5'h13;
	localparam logic [4:0]  OP_LOAD         = 5'h14;
	// operand addressing modes, code 7 is illegal
	localparam logic [2:0]  AM_REG          = 3'h0;
	localparam logic [2:0]  AM_IND_REG      = 3'h1;
	localparam logic [2:0]  AM_INDEXED      = 3'h2;
	localparam logic [2:0]  AM_DIRECT       = 3'h3;
	localparam logic [2:0]  AM_RELATIVE     = 3'h4;
	localparam logic [2:0]  AM_IMMEDIATE    = 3'h5;
	localparam logic [2:0]  AM_INDIRECT     = 3'h6;
	localparam logic [2:0]  AM_ILLEGAL      = 3'h7;
	// bus responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// File: src/csfl_shadow.sv
// csfl_shadow: saved copy of the status register for fast interrupts
`timescale 1ns/100ps
module csfl_shadow
	import csfl_pkg::*;
(
	// clock and control
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// save port
	input  wire logic       save,
	input  wire logic [7:0] save_data,
	// saved value
	output logic      [7:0] saved_q
);
	typedef struct packed {
		logic [7:0] saved;
	} csfl_shadow_t;

	csfl_shadow_t s_q;
	csfl_shadow_t s_d;

	always_comb begin
		s_d = s_q;
		if (save) begin
			s_d.saved = save_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '{saved: RST_SHADOW};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign saved_q = s_q.saved;
endmodule

// File: src/csfl_top.sv
// csfl_top: condition-status register with its flag update logic on AXI4-Lite
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module csfl_top
	import csfl_pkg::*;
(
	// clock, reset, enable
	input  wire logic              MCLK,
	input  wire logic              RESET_N,
	input  wire logic              CLK_EN,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	// axi4-lite write data
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	// axi4-lite read data
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	// core status
	output logic [7:0]             STATUS_OUT,
	output logic                   FAST_IRQ_ACTIVE,
	output logic                   BANK_SEL
);
	typedef struct packed {
		logic [7:0]        flags;
		logic [7:0]        result;
		logic              err;
		logic [2:0]        mode;
		logic [7:0]        opa;
		logic [7:0]        opb;
		logic              aw_full;
		logic [ADDR_W-1:0] awaddr;
		logic              w_full;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              aw_rdy;
		logic              w_rdy;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              ar_rdy;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} csfl_state_t;

	localparam csfl_state_t ST_RESET = '{
		flags: RST_FLAGS, result: 8'h00, err: 1'b0, mode: AM_REG,
		opa: 8'h00, opb: 8'h00, aw_full: 1'b0, awaddr: '0, w_full: 1'b0,
		wdata: 32'h00000000, wstrb: 4'h0, aw_rdy: 1'b1, w_rdy: 1'b1,
		bvalid: 1'b0, bresp: RESP_OKAY, ar_rdy: 1'b1, rvalid: 1'b0,
		rdata: 32'h00000000, rresp: RESP_OKAY};

	csfl_state_t s_q;
	csfl_state_t s_d;

	logic [7:0] shadow_q;
	logic       shadow_save;
	logic       wr_go;
	logic       exec;
	logic [4:0] exec_op;
	logic [2:0] exec_mode;

	// returns {carry, half, overflow, result}; sub computes a - b - ci
	function automatic logic [10:0] addsub(input logic [7:0] a, input logic [7:0] b,
		input logic ci, input logic sub);
		logic [7:0] bb;
		logic       c0;
		logic [8:0] s9;
		logic [4:0] s5;
		logic       vv;
		bb = sub ? ~b : b;
		c0 = sub ? ~ci : ci;
		s9 = {1'b0, a} + {1'b0, bb} + {8'h00, c0};
		s5 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, c0};
		vv = (a[7] == bb[7]) && (s9[7] != a[7]);
		return {sub ? ~s9[8] : s9[8], sub ? ~s5[4] : s5[4], vv, s9[7:0]};
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [4:0] w;
		w = {a[ADDR_W-1:2], 2'b00};
		return (w == OFS_STATUS) || (w == OFS_OP_CTRL) || (w == OFS_OPERANDS)
			|| (w == OFS_RESULT);
	endfunction

	assign wr_go     = s_q.aw_full && s_q.w_full && !s_q.bvalid;
	assign exec      = wr_go && ({s_q.awaddr[ADDR_W-1:2], 2'b00} == OFS_OP_CTRL)
		&& s_q.wstrb[0];
	assign exec_op   = s_q.wdata[OPC_OP_LO +: 5];
	assign exec_mode = s_q.wdata[OPC_MODE_LO +: 3];
	// the fast entry is blocked while a fast interrupt is already in progress
	assign shadow_save = exec && (exec_mode != AM_ILLEGAL) && (exec_op == OP_FAST_IRQ)
		&& !s_q.flags[FLG_FAST_IRQ];

	csfl_shadow u_shadow (
		.clk       (MCLK),
		.rst_n     (RESET_N),
		.ce        (CLK_EN),
		.save      (shadow_save),
		.save_data (s_q.flags),
		.saved_q   (shadow_q)
	);

	always_comb begin
		logic [10:0] as;
		logic [7:0]  f;
		logic [7:0]  r;
		logic        upd;
		logic        dst_flags;
		logic [4:0]  wa;
		as        = 11'h000;
		f         = s_q.flags;
		r         = s_q.result;
		upd       = 1'b0;
		dst_flags = 1'b0;
		wa        = {s_q.awaddr[ADDR_W-1:2], 2'b00};
		s_d       = s_q;
		// bus handshakes
		if (s_q.aw_rdy && S_AXI_AWVALID) begin
			s_d.aw_full = 1'b1;
			s_d.awaddr  = S_AXI_AWADDR;
		end
		if (s_q.w_rdy && S_AXI_WVALID) begin
			s_d.w_full = 1'b1;
			s_d.wdata  = S_AXI_WDATA;
			s_d.wstrb  = S_AXI_WSTRB;
		end
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid = 1'b0;
		end
		if (wr_go) begin
			s_d.aw_full = 1'b0;
			s_d.w_full  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (wa == OFS_STATUS && s_q.wstrb[0]) begin
				f = s_q.wdata[7:0];
			end
			if (wa == OFS_OPERANDS) begin
				if (s_q.wstrb[0]) begin
					s_d.opa = s_q.wdata[OPR_A_LO +: 8];
				end
				if (s_q.wstrb[1]) begin
					s_d.opb = s_q.wdata[OPR_B_LO +: 8];
				end
			end
		end
		if (exec) begin
			dst_flags   = s_q.wstrb[1] && s_q.wdata[OPC_DST_FLAGS];
			s_d.mode    = exec_mode;
			s_d.err     = (exec_mode == AM_ILLEGAL);
			if (exec_mode == AM_ILLEGAL) begin
				s_d.bresp = RESP_SLVERR;
			end else begin
				upd = 1'b1;
				unique case (exec_op)
				OP_ADD, OP_ADC: begin
					as = addsub(s_q.opa, s_q.opb, exec_op == OP_ADC && f[FLG_CARRY], 1'b0);
					f[FLG_DEC] = 1'b0;
				end
				OP_SUB, OP_SBC: begin
					as = addsub(s_q.opa, s_q.opb, exec_op == OP_SBC && f[FLG_CARRY], 1'b1);
					f[FLG_DEC] = 1'b1;
				end
				OP_AND: as = {3'b000, s_q.opa & s_q.opb};
				OP_OR:  as = {3'b000, s_q.opa | s_q.opb};
				OP_XOR: as = {3'b000, s_q.opa ^ s_q.opb};
				OP_RL:  as = {s_q.opa[7], 2'b00, s_q.opa[6:0], s_q.opa[7]};
				OP_RLC: as = {s_q.opa[7], 2'b00, s_q.opa[6:0], f[FLG_CARRY]};
				OP_RR:  as = {s_q.opa[0], 2'b00, s_q.opa[0], s_q.opa[7:1]};
				OP_RRC: as = {s_q.opa[0], 2'b00, f[FLG_CARRY], s_q.opa[7:1]};
				OP_SRA: as = {s_q.opa[0], 2'b00, s_q.opa[7], s_q.opa[7:1]};
				default: upd = 1'b0;
				endcase
				if (upd) begin
					r = as[7:0];
					f[FLG_ZERO] = (as[7:0] == 8'h00);
					f[FLG_SIGN] = as[7];
					unique case (exec_op)
					OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
						f[FLG_CARRY] = as[10];
						f[FLG_HALF]  = as[9];
						f[FLG_OVFL]  = as[8];
					end
					OP_AND, OP_OR, OP_XOR: begin
						f[FLG_OVFL] = 1'b0;
					end
					default: begin
						// rotates and shifts: last bit out, sign change as overflow
						f[FLG_CARRY] = as[10];
						f[FLG_OVFL]  = as[7] ^ s_q.opa[7];
					end
					endcase
				end
				unique case (exec_op)
				OP_SCF:       f[FLG_CARRY] = 1'b1;
				OP_RCF:       f[FLG_CARRY] = 1'b0;
				OP_CCF:       f[FLG_CARRY] = ~f[FLG_CARRY];
				OP_SEL_BANK0: f[FLG_BANK] = 1'b0;
				OP_SEL_BANK1: f[FLG_BANK] = 1'b1;
				OP_FAST_IRQ:  f[FLG_FAST_IRQ] = 1'b1;
				OP_IRQ_RETURN: begin
					// a normal return restores from the stack outside this block
					if (s_q.flags[FLG_FAST_IRQ]) begin
						f = {shadow_q[7:2], 1'b0, shadow_q[0]};
					end
				end
				OP_LOAD: begin
					r = s_q.opa;
					// a load leaves the flags alone unless it targets them
					if (dst_flags) begin
						f = s_q.opa;
					end
				end
				// every other code keeps the status bits as the ALU update above left them
				default: f = f;
				endcase
				// on a collision the flag update is kept, the dst bit ignored
			end
		end
		s_d.flags  = f;
		s_d.result = r;
		// read channel
		if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid = 1'b0;
		end
		if (s_q.ar_rdy && S_AXI_ARVALID) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
			unique case ({S_AXI_ARADDR[ADDR_W-1:2], 2'b00})
			OFS_STATUS:   s_d.rdata = {24'h000000, s_q.flags};
			OFS_OPERANDS: s_d.rdata = {16'h0000, s_q.opb, s_q.opa};
			OFS_RESULT:   s_d.rdata = {20'h00000, s_q.mode, s_q.err, s_q.result};
			default:      s_d.rdata = 32'h00000000;
			endcase
		end
		s_d.aw_rdy = !s_d.aw_full;
		s_d.w_rdy  = !s_d.w_full;
		s_d.ar_rdy = !s_d.rvalid;
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			s_q <= ST_RESET;
		end else if (CLK_EN) begin
			s_q <= s_d;
		end
	end

	assign S_AXI_AWREADY   = s_q.aw_rdy;
	assign S_AXI_WREADY    = s_q.w_rdy;
	assign S_AXI_BRESP     = s_q.bresp;
	assign S_AXI_BVALID    = s_q.bvalid;
	assign S_AXI_ARREADY   = s_q.ar_rdy;
	assign S_AXI_RDATA     = s_q.rdata;
	assign S_AXI_RRESP     = s_q.rresp;
	assign S_AXI_RVALID    = s_q.rvalid;
	assign STATUS_OUT      = s_q.flags;
	assign FAST_IRQ_ACTIVE = s_q.flags[FLG_FAST_IRQ];
	assign BANK_SEL        = s_q.flags[FLG_BANK];

	// checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	logic go;
	assign go = exec && CLK_EN && (exec_mode != AM_ILLEGAL);

	property p_add_carry;
		go && exec_op == OP_ADD |=> STATUS_OUT[FLG_CARRY]
			== (({1'b0, $past(s_q.opa)} + {1'b0, $past(s_q.opb)}) >= 9'h100);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
	property p_sub_dec;
		go && (exec_op == OP_SUB || exec_op == OP_SBC) |=> STATUS_OUT[FLG_DEC];
	endproperty
	a_sub_dec: assert property (p_sub_dec) else $error("decimal bit not set");
	property p_and_flags;
		go && exec_op == OP_AND |=> !STATUS_OUT[FLG_OVFL]
			&& STATUS_OUT[FLG_ZERO] == (($past(s_q.opa) & $past(s_q.opb)) == 8'h00)
			&& STATUS_OUT[FLG_SIGN] == $past(s_q.opa[7] & s_q.opb[7])
			&& STATUS_OUT[FLG_CARRY] == $past(STATUS_OUT[FLG_CARRY]);
	endproperty
	a_and_flags: assert property (p_and_flags) else $error("and flags wrong");
	property p_fast_entry;
		go && exec_op == OP_FAST_IRQ |=> FAST_IRQ_ACTIVE && ($past(FAST_IRQ_ACTIVE)
			? shadow_q == $past(shadow_q) : shadow_q == $past(STATUS_OUT));
	endproperty
	a_fast_entry: assert property (p_fast_entry) else $error("fast entry wrong");
	property p_fast_return;
		go && exec_op == OP_IRQ_RETURN && FAST_IRQ_ACTIVE |=> !FAST_IRQ_ACTIVE
			&& STATUS_OUT[7:2] == $past(shadow_q[7:2]);
	endproperty
	a_fast_return: assert property (p_fast_return) else $error("fast return wrong");
	property p_bank;
		go && (exec_op == OP_SEL_BANK0 || exec_op == OP_SEL_BANK1)
			|=> BANK_SEL == ($past(exec_op) == OP_SEL_BANK1);
	endproperty
	a_bank: assert property (p_bank) else $error("bank bit wrong");
	property p_load;
		CLK_EN && wr_go && !exec && {s_q.awaddr[ADDR_W-1:2], 2'b00} == OFS_STATUS
			&& s_q.wstrb[0] |=> STATUS_OUT == $past(s_q.wdata[7:0]) && S_AXI_BVALID;
	endproperty
	a_load: assert property (p_load) else $error("status write lost");
	property p_bad_mode;
		exec && CLK_EN && exec_mode == AM_ILLEGAL |=> s_q.err
			&& $stable(STATUS_OUT) && S_AXI_BRESP == RESP_SLVERR;
	endproperty
	a_bad_mode: assert property (p_bad_mode) else $error("illegal mode accepted");
	property p_hold;
		go && exec_op == OP_NOP |=> $stable(STATUS_OUT);
	endproperty
	a_hold: assert property (p_hold) else $error("flags changed on nop");
	property p_or_ovfl;
		go && (exec_op == OP_OR || exec_op == OP_XOR) |=> !STATUS_OUT[FLG_OVFL]
			&& STATUS_OUT[FLG_SIGN] == ($past(exec_op == OP_OR)
			? $past(s_q.opa[7] | s_q.opb[7]) : $past(s_q.opa[7] ^ s_q.opb[7]));
	endproperty
	a_or_ovfl: assert property (p_or_ovfl) else $error("logic flags wrong");
	property p_wr_resp;
		CLK_EN && wr_go |=> S_AXI_BVALID;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no write response");

	c_add: cover property (go && exec_op == OP_ADC);
	c_fast: cover property (go && exec_op == OP_FAST_IRQ ##[1:50] go && exec_op == OP_IRQ_RETURN);
	c_bank: cover property (go && exec_op == OP_SEL_BANK1);
	c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule

// File: sim/tb_cpu_status_flag_logic.sv
// tb_cpu_status_flag_logic: self-checking bench for the condition-status flag logic
`timescale 1ns/100ps
module tb_cpu_status_flag_logic
	import csfl_pkg::*;
;
	typedef struct packed {
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  s;
	} csfl_rexp_t;
	localparam int LIMIT = 20000;
	// boundary cases: op, operand a, operand b
	localparam logic [20:0] BND [8] = '{
		{OP_ADD, 8'h7F, 8'h01}, {OP_AND, 8'hF0, 8'h0F}, {OP_ADD, 8'hFF, 8'h01},
		{OP_ADC, 8'h7E, 8'h00}, {OP_SUB, 8'h80, 8'h01}, {OP_SUB, 8'h00, 8'h01},
		{OP_SBC, 8'h10, 8'h00}, {OP_XOR, 8'h81, 8'h01}};
	logic        mclk, reset_n, clk_en;
	logic [4:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, fast_irq, bank_sel;
	logic [31:0] wdata, rdata, rng;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [7:0]  status_out, st, sh, res, opa, opb;
	logic        err_m;
	logic [2:0]  mode_m;
	logic [1:0]  wq [$];
	csfl_rexp_t  rq [$];
	csfl_rexp_t  e;
	int          mismatches, n_tests, cyc;

	csfl_top dut (
		.MCLK(mclk), .RESET_N(reset_n), .CLK_EN(clk_en),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .STATUS_OUT(status_out),
		.FAST_IRQ_ACTIVE(fast_irq), .BANK_SEL(bank_sel)
	);

	initial mclk = 1'b0;
	always #2 mclk = ~mclk;

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic axi_wr(input logic [4:0] ad, input logic [31:0] d, input logic [3:0] sb,
			input logic [1:0] rsp);
		wq.push_back(rsp);
		@(posedge mclk);
		awaddr <= ad;
		wdata <= d;
		wstrb <= sb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [4:0] ad, input logic [31:0] d, input logic [1:0] rsp);
		rq.push_back('{d, rsp, st});
		@(posedge mclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask

	task automatic rd_status();
		axi_rd(OFS_STATUS, {24'h0, st}, RESP_OKAY);
	endtask

	task automatic rd_result();
		axi_rd(OFS_RESULT, {20'h0, mode_m, err_m, res}, RESP_OKAY);
	endtask

	task automatic set_ops(input logic [7:0] a, input logic [7:0] b);
		opa = a;
		opb = b;
		// upper bytes carry junk that the strobes must keep out
		axi_wr(OFS_OPERANDS, {16'hFFFF, b, a}, 4'h3, RESP_OKAY);
	endtask

	// reference flag behaviour; flag update wins over a status destination
	task automatic model(input logic [4:0] op, input logic dst);
		logic [8:0] r;
		logic       ci;
		logic       alu;
		alu = 1'b1;
		ci = (op == OP_ADC || op == OP_SBC) ? st[FLG_CARRY] : 1'b0;
		r = {st[FLG_CARRY], 8'h00};
		case (op)
			OP_ADD, OP_ADC: begin
				r = {1'b0, opa} + {1'b0, opb} + {8'h0, ci};
				st[FLG_HALF] = ({1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, ci}) > 5'h0F;
				st[FLG_OVFL] = (opa[7] == opb[7]) && (r[7] != opa[7]);
				st[FLG_DEC] = 1'b0;
			end
			OP_SUB, OP_SBC: begin
				r = {1'b0, opa} - {1'b0, opb} - {8'h0, ci};
				st[FLG_HALF] = {1'b0, opa[3:0]} < ({1'b0, opb[3:0]} + {4'h0, ci});
				st[FLG_OVFL] = (opa[7] != opb[7]) && (r[7] != opa[7]);
				st[FLG_DEC] = 1'b1;
			end
			OP_AND: r[7:0] = opa & opb;
			OP_OR: r[7:0] = opa | opb;
			OP_XOR: r[7:0] = opa ^ opb;
			OP_RL: r = {opa[7], opa[6:0], opa[7]};
			OP_RLC: r = {opa[7], opa[6:0], st[FLG_CARRY]};
			OP_RR: r = {opa[0], opa[0], opa[7:1]};
			OP_RRC: r = {opa[0], st[FLG_CARRY], opa[7:1]};
			OP_SRA: r = {opa[0], opa[7], opa[7:1]};
			default: alu = 1'b0;
		endcase
		if (op inside {OP_AND, OP_OR, OP_XOR})
			st[FLG_OVFL] = 1'b0;
		if (op inside {[OP_RL:OP_SRA]})
			st[FLG_OVFL] = r[7] ^ opa[7];
		case (op)
			OP_SCF: st[FLG_CARRY] = 1'b1;
			OP_RCF: st[FLG_CARRY] = 1'b0;
			OP_CCF: st[FLG_CARRY] = ~st[FLG_CARRY];
			OP_SEL_BANK0: st[FLG_BANK] = 1'b0;
			OP_SEL_BANK1: st[FLG_BANK] = 1'b1;
			OP_FAST_IRQ: if (!st[FLG_FAST_IRQ]) begin
				sh = st;
				st[FLG_FAST_IRQ] = 1'b1;
			end
			OP_IRQ_RETURN: if (st[FLG_FAST_IRQ])
				st = sh & 8'hFD;
			OP_LOAD: begin
				res = opa;
				if (dst)
					st = opa;
			end
			default: ;
		endcase
		if (alu) begin
			st[7:5] = {r[8], r[7:0] == 8'h00, r[7]};
			res = r[7:0];
		end
	endtask

	task automatic do_op(input logic [4:0] op, input logic [2:0] md, input logic dst);
		logic [1:0] rsp;
		rsp = RESP_OKAY;
		mode_m = md;
		err_m = (md == AM_ILLEGAL);
		if (err_m)
			rsp = RESP_SLVERR;
		else
			model(op, dst);
		axi_wr(OFS_OP_CTRL, {23'h0, dst, md, op}, 4'hF, rsp);
	endtask

	always @(posedge mclk) begin
		if (bvalid === 1'b1 && bready === 1'b1) begin
			if (wq.size() > 0)
				check("bresp", {30'h0, bresp}, {30'h0, wq.pop_front()});
			else
				mismatches++;
		end
		if (rvalid === 1'b1 && rready === 1'b1) begin
			if (rq.size() > 0) begin
				e = rq.pop_front();
				check("rdata", rdata, e.d);
				check("rresp", {30'h0, rresp}, {30'h0, e.r});
				check("status_out", {24'h0, status_out}, {24'h0, e.s});
				check("fast_irq_active", {31'h0, fast_irq}, {31'h0, e.s[FLG_FAST_IRQ]});
				check("bank_sel", {31'h0, bank_sel}, {31'h0, e.s[FLG_BANK]});
			end else
				mismatches++;
		end
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc > LIMIT) begin
			mismatches++;
			tally_and_finish();
		end
	end

	initial begin
		{awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
		{reset_n, clk_en, rng, mismatches, n_tests, cyc} = {2'b01, 32'd65640, 96'h0};
		{st, sh, res, opa, opb, err_m, mode_m} = {RST_FLAGS, RST_SHADOW, 28'h0};
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		rd_status();
		axi_rd(5'h10, 32'h0, RESP_SLVERR);
		axi_wr(5'h14, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
		axi_rd(OFS_OP_CTRL, 32'h0, RESP_OKAY);
		st = 8'hA5;
		axi_wr(OFS_STATUS, 32'hFFFF_FFA5, 4'hF, RESP_OKAY);
		rd_status();
		set_ops(8'h3C, 8'h00);
		do_op(OP_LOAD, AM_REG, 1'b0);
		rd_result();
		do_op(OP_LOAD, AM_DIRECT, 1'b1);
		rd_status();
		for (int i = 0; i < 8; i++) begin
			set_ops(BND[i][15:8], BND[i][7:0]);
			do_op(BND[i][20:16], AM_IMMEDIATE, 1'b0);
			rd_status();
			rd_result();
		end
		for (int m = 0; m < 8; m++) begin
			do_op(OP_ADD, 3'(m), 1'b0);
			rd_status();
			rd_result();
		end
		// random dst bit also drives the flag-op collision case
		for (int k = 0; k < 3; k++) begin
			for (int o = 0; o <= 21; o++) begin
				rng = rnd();
				set_ops(rng[7:0], rng[15:8]);
				do_op(5'(o), 3'(rng[18:16] % 3'd7), rng[20]);
				rd_status();
				if (o inside {[1:12], 20})
					rd_result();
			end
		end
		st = 8'h58;
		axi_wr(OFS_STATUS, 32'h58, 4'h1, RESP_OKAY);
		do_op(OP_FAST_IRQ, AM_REG, 1'b0);
		rd_status();
		do_op(OP_SEL_BANK1, AM_REG, 1'b0);
		do_op(OP_FAST_IRQ, AM_REG, 1'b0);
		do_op(OP_SCF, AM_REG, 1'b0);
		rd_status();
		do_op(OP_IRQ_RETURN, AM_REG, 1'b0);
		rd_status();
		do_op(OP_IRQ_RETURN, AM_REG, 1'b0);
		do_op(OP_SEL_BANK1, AM_REG, 1'b0);
		rd_status();
		do_op(OP_SEL_BANK0, AM_REG, 1'b0);
		rd_status();
		clk_en <= 1'b0;
		repeat (5) @(posedge mclk);
		check("frozen status", {24'h0, status_out}, {24'h0, st});
		clk_en <= 1'b1;
		rd_status();
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		{st, sh} = {RST_FLAGS, RST_SHADOW};
		rd_status();
		tally_and_finish();
	end
endmodule
